// [ebp_pkg.sv]
// Contract
// - hold request low puts the bus into hold 2.5 cycles later than production part; the code rounds this up to 3 whole cycles.
// - every address outside the special-function region maps to emulation memory, except non-internal ones on target-side mapping.
// - debugger vector areas accept writes but reads return indefinite data.
// - special-function accesses on target-side mapping leave the data bus floating.
// - special-function and internal accesses keep strobes and chip select high, drive ale.
// - external accesses drive address, select, data on writes, pulse matching strobe low.
// - stop mode floats data, retains address and select, strobes and ale high.
// - wait mode floats data, retains address and select, strobes and ale high.
// - program stopped drives address, select and ale, floats data, read strobe only.
package ebp_pkg;
    // ****************************************
    // address map
    // ****************************************
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;
    localparam logic [19:0] SPEC_LO = 20'h00000;
    localparam logic [19:0] SPEC_HI = 20'h003ff;
    localparam logic [19:0] DBG_CALL_LO = 20'hffff4;
    localparam logic [19:0] DBG_CALL_HI = 20'hffff7;
    localparam logic [19:0] STEP_LO = 20'hfffec;
    localparam logic [19:0] STEP_HI = 20'hfffef;
    localparam logic [19:0] BRK_LO = 20'hfffe4;
    localparam logic [19:0] BRK_HI = 20'hfffe7;
    // value returned from the debugger-owned vector areas (arbitrary)
    localparam logic [15:0] INDEF_DATA = 16'hdead;
    // ****************************************
    // timing: hold delay in half cycles
    // ****************************************
    localparam int HOLD_DELAY_HALF = 5;
    localparam int HOLD_DELAY_CYC = (HOLD_DELAY_HALF + 1) / 2;
    localparam logic [2:0] HOLD_CNT = 3'(HOLD_DELAY_CYC);

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [3:0] {
        RUN_EXEC = 4'h1,
        RUN_STOP = 4'h2,
        RUN_WAIT = 4'h4,
        RUN_HALT = 4'h8
    } ebp_run_t;
    typedef enum logic [2:0] {
        AREA_SPEC = 3'h1,
        AREA_INT = 3'h2,
        AREA_EXT = 3'h4
    } ebp_area_t;
endpackage : ebp_pkg

// [ebp_bus_pins.sv]
`timescale 1ns/1ps
`default_nettype none
module ebp_bus_pins
    import ebp_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // evaluation core access
    input wire logic [3:0] runState,
    input wire logic accValid,
    input wire logic accWrite,
    input wire logic [ADDR_W-1:0] accAddr,
    input wire logic accByteHigh,
    input wire logic [DATA_W-1:0] accWdata,
    input wire logic isInternal,
    input wire logic targetSideMap,
    output logic useEmuMem,
    output logic [DATA_W-1:0] accRdata,
    output logic accRdataValid,
    // emulation memory read data
    input wire logic [DATA_W-1:0] emuRdata,
    // target bus pins
    output logic [ADDR_W-1:0] addrOut,
    output logic addrOe,
    output logic byteHighEnableN,
    output logic [DATA_W-1:0] dataOut,
    output logic dataOe,
    input wire logic [DATA_W-1:0] dataIn,
    output logic readN,
    output logic writeN,
    output logic chipSelectN,
    output logic ale,
    // hold
    input wire logic holdReqN,
    output logic holdActive
);
    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic bhen;
        logic csn;
        logic [2:0] holdCnt;
        logic hold;
        logic [DATA_W-1:0] rdata;
        logic rvalid;
    } ebp_state_t;
    ebp_state_t st_r, st_nxt;

    // decode used for area and vector checks
    function automatic logic inRange(input logic [19:0] a,
                                     input logic [19:0] lo,
                                     input logic [19:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction : inRange

    logic isSpecial, isVec, isExt, active;
    ebp_area_t area;

    // ****************************************
    // area decode
    // ****************************************
    always_comb begin
        isSpecial = inRange(accAddr, SPEC_LO, SPEC_HI);
        isVec = inRange(accAddr, DBG_CALL_LO, DBG_CALL_HI) ||
                inRange(accAddr, STEP_LO, STEP_HI) ||
                inRange(accAddr, BRK_LO, BRK_HI);
        isExt = !isSpecial && !isInternal && targetSideMap;
        if (isSpecial) begin
            area = AREA_SPEC;
        end else if (isExt) begin
            area = AREA_EXT;
        end else begin
            area = AREA_INT;
        end
        useEmuMem = accValid && !isSpecial && !isExt;
        active = accValid && (runState == RUN_EXEC) && !st_r.hold;
    end

    // ****************************************
    // pin selection; core state no slower than one cycle
    // ****************************************
    // combinational pin selection
    always_comb begin
        addrOut = st_r.addr;
        byteHighEnableN = st_r.bhen;
        chipSelectN = st_r.csn;
        addrOe = !st_r.hold;
        dataOut = accWdata;
        dataOe = 1'b0;
        readN = 1'b1;
        writeN = 1'b1;
        ale = 1'b0;
        case (runState)
            RUN_EXEC: begin
                if (active) begin
                    addrOut = accAddr;
                    byteHighEnableN = !accByteHigh;
                    ale = 1'b1;
                    case (area)
                        AREA_SPEC: chipSelectN = 1'b1;
                        AREA_INT: chipSelectN = 1'b1;
                        AREA_EXT: begin
                            chipSelectN = 1'b0;
                            dataOe = accWrite;
                            readN = accWrite;
                            writeN = !accWrite;
                        end
                        default: chipSelectN = 1'b1;
                    endcase
                end
            end
            RUN_STOP: ale = 1'b1;
            RUN_WAIT: ale = 1'b1;
            RUN_HALT: begin
                ale = 1'b1;
                // debugger accesses go out on the bus; only reads strobe
                if (accValid && !st_r.hold) begin
                    addrOut = accAddr;
                    byteHighEnableN = !accByteHigh;
                    chipSelectN = (area != AREA_EXT);
                    readN = !(!accWrite && (area == AREA_EXT));
                end
            end
            default: ale = 1'b0;
        endcase
        if (st_r.hold) begin
            dataOe = 1'b0;
        end
        accRdata = st_r.rdata;
        accRdataValid = st_r.rvalid;
        holdActive = st_r.hold;
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.addr = addrOut;
        st_nxt.bhen = byteHighEnableN;
        st_nxt.csn = chipSelectN;
        st_nxt.rvalid = accValid && !accWrite;
        if (isVec) begin
            st_nxt.rdata = INDEF_DATA;
        end else if (area == AREA_EXT) begin
            st_nxt.rdata = dataIn;
        end else begin
            st_nxt.rdata = emuRdata;
        end
        // delayed hold entry; delay counted in whole cycles
        if (holdReqN) begin
            st_nxt.holdCnt = 3'h0;
            st_nxt.hold = 1'b0;
        end else if (st_r.holdCnt < HOLD_CNT) begin
            st_nxt.holdCnt = st_r.holdCnt + 3'h1;
        end else begin
            st_nxt.hold = 1'b1;
        end
    end

    // one register stage for the whole state struct
    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_r <= '{addr: '0, bhen: 1'b1, csn: 1'b1, holdCnt: 3'h0,
                      hold: 1'b0, rdata: '0, rvalid: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    // hold entry is exact in both directions, so check early and late
    // hold entry delay
    hold_delay_a: assert property (@(posedge clk)
        disable iff (!resetn)
        $fell(holdReqN) ##1 !holdReqN [*3] |=> holdActive)
        else $error("hold not entered");
    hold_early_a: assert property (@(posedge clk)
        disable iff (!resetn)
        $fell(holdReqN) ##1 !holdReqN [*2] |=> !holdActive)
        else $error("hold entered early");
    hold_quiet_a: assert property (@(posedge clk)
        disable iff (!resetn)
        holdActive |-> !addrOe && !dataOe && readN && writeN)
        else $error("bus active during hold");
    spec_float_a: assert property (@(posedge clk)
        disable iff (!resetn)
        (area == AREA_SPEC) |-> !dataOe)
        else $error("data driven in special area");
    int_strobe_a: assert property (@(posedge clk)
        disable iff (!resetn)
        (area != AREA_EXT) |-> readN && writeN && !dataOe)
        else $error("strobe on internal access");
    ext_write_a: assert property (@(posedge clk)
        disable iff (!resetn)
        active && area == AREA_EXT && accWrite |-> !writeN && dataOe
        && !chipSelectN) else $error("bad external write");
    ext_read_a: assert property (@(posedge clk)
        disable iff (!resetn)
        active && area == AREA_EXT && !accWrite |-> !readN && writeN
        && !dataOe && !chipSelectN) else $error("bad external read");
    stop_hold_a: assert property (@(posedge clk)
        disable iff (!resetn)
        runState == RUN_STOP && $past(runState) == RUN_STOP |->
        $stable(addrOut) && $stable(byteHighEnableN) &&
        $stable(chipSelectN) && ale && readN && writeN && !dataOe)
        else $error("stop pins wrong");
    wait_hold_a: assert property (@(posedge clk)
        disable iff (!resetn)
        runState == RUN_WAIT && $past(runState) == RUN_WAIT |->
        $stable(addrOut) && $stable(byteHighEnableN) &&
        $stable(chipSelectN) && ale && readN && writeN && !dataOe)
        else $error("wait pins wrong");
    halt_pins_a: assert property (@(posedge clk)
        disable iff (!resetn)
        runState == RUN_HALT |-> writeN && !dataOe && ale)
        else $error("halt pins wrong");
    halt_addr_a: assert property (@(posedge clk)
        disable iff (!resetn)
        runState == RUN_HALT && accValid && !holdActive |->
        addrOut == accAddr && byteHighEnableN == !accByteHigh)
        else $error("halt address not driven");
    vec_read_a: assert property (@(posedge clk)
        disable iff (!resetn)
        accValid && !accWrite && isVec |=> accRdata == INDEF_DATA)
        else $error("vector read not indefinite");
endmodule : ebp_bus_pins
`default_nettype wire

// [ebp_target_mem.sv]
`timescale 1ns/1ps
`default_nettype none
// target-side memory, answers only selected external reads
module ebp_target_mem
    import ebp_pkg::*;
(
    // target bus
    input wire logic clk,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic readN,
    input wire logic writeN,
    input wire logic chipSelectN,
    output logic [DATA_W-1:0] rdata
);
    logic [DATA_W-1:0] mem [16];
    logic [DATA_W-1:0] last;
    // released bus shows the inverse of its last value, never a stale copy
    always_comb begin
        rdata = (!readN && !chipSelectN) ? mem[addr[3:0]] : ~last;
    end
    // small store: only the low address bits are decoded
    always_ff @(posedge clk) begin
        last <= rdata;
        if (!writeN && !chipSelectN) begin
            mem[addr[3:0]] <= wdata;
        end
    end
endmodule : ebp_target_mem
`default_nettype wire

// [emulator_external_bus_pin_states_test.sv]
`timescale 1ns/1ps
`default_nettype none
module emulator_external_bus_pin_states_test;
    import ebp_pkg::*;
    logic clk = 1'b0, resetn = 1'b0, accValid = 1'b0, accWrite = 1'b0;
    logic isInternal = 1'b0, targetSideMap = 1'b0, holdReqN = 1'b1;
    logic accByteHigh = 1'b1, useEmuMem, accRdataValid, addrOe, dataOe;
    logic byteHighEnableN, readN, writeN, chipSelectN, ale, holdActive;
    logic [3:0] runState = 4'h1;
    logic [19:0] accAddr = 20'h00000, addrOut;
    logic [15:0] accWdata = 16'h0000, emuRdata = 16'h1234;
    logic [15:0] accRdata, dataOut, dataIn;
    int failures = 0, num_checks = 0;
    localparam logic [19:0] VEC [6] = '{DBG_CALL_LO, DBG_CALL_HI, STEP_LO, STEP_HI,
        BRK_LO, BRK_HI};
    ebp_bus_pins i_dut (.clk(clk), .resetn(resetn), .runState(runState),
        .accValid(accValid), .accWrite(accWrite), .accAddr(accAddr),
        .accByteHigh(accByteHigh), .accWdata(accWdata),
        .isInternal(isInternal), .targetSideMap(targetSideMap),
        .useEmuMem(useEmuMem), .accRdata(accRdata),
        .accRdataValid(accRdataValid), .emuRdata(emuRdata),
        .addrOut(addrOut), .addrOe(addrOe),
        .byteHighEnableN(byteHighEnableN), .dataOut(dataOut),
        .dataOe(dataOe), .dataIn(dataIn), .readN(readN), .writeN(writeN),
        .chipSelectN(chipSelectN), .ale(ale), .holdReqN(holdReqN),
        .holdActive(holdActive));
    ebp_target_mem i_tgt (.clk(clk), .addr(addrOut), .wdata(dataOut),
        .readN(readN), .writeN(writeN), .chipSelectN(chipSelectN),
        .rdata(dataIn));
    // 100 ns period
    initial begin
        forever #50 clk = ~clk;
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // one access cycle; pins are combinational, so look 10 ns in
    task automatic acc(input logic [3:0] rs, input logic v, input logic w,
        input logic intl, input logic tsm, input logic [19:0] a);
        @(posedge clk);
        #1;
        runState = rs; accValid = v; accWrite = w;
        isInternal = intl; targetSideMap = tsm; accAddr = a;
        #10;
    endtask : acc
    task automatic next_edge();
        @(posedge clk);
        #1;
    endtask : next_edge
    task automatic test_ext();
        accWdata = 16'h5a3c;
        acc(4'h1, 1'b1, 1'b1, 1'b0, 1'b1, 20'h12345);
        chk({chipSelectN, writeN, readN, dataOe, ale, useEmuMem}, 6'h0e);
        chk({addrOut, dataOut, byteHighEnableN},
            {20'h12345, 16'h5a3c, 1'b0});
        acc(4'h1, 1'b1, 1'b0, 1'b0, 1'b1, 20'h12345);
        chk({chipSelectN, writeN, readN, dataOe}, 4'h4);
        next_edge();
        chk({accRdataValid, accRdata}, {1'b1, 16'h5a3c});
        $display("test ext done");
    endtask : test_ext
    task automatic test_local();
        acc(4'h1, 1'b1, 1'b0, 1'b0, 1'b1, SPEC_HI);
        chk({chipSelectN, writeN, readN, dataOe, ale, useEmuMem},
            6'h3a);
        acc(4'h1, 1'b1, 1'b1, 1'b0, 1'b1, 20'h00200);
        chk({chipSelectN, writeN, readN, dataOe, ale, useEmuMem},
            6'h3a);
        acc(4'h1, 1'b1, 1'b1, 1'b1, 1'b0, 20'h00500);
        chk({chipSelectN, writeN, readN, dataOe, ale, addrOut},
            {5'h1d, 20'h00500});
        acc(4'h1, 1'b1, 1'b0, 1'b0, 1'b0, 20'h40000);
        chk(useEmuMem, 1'b1);
        next_edge();
        chk(accRdata, 16'h1234);
        for (int i = 0; i < 6; i++) begin
            acc(4'h1, 1'b1, 1'b0, 1'b0, 1'b0, VEC[i]);
            next_edge();
            chk(accRdata, INDEF_DATA);
        end
        $display("test local done");
    endtask : test_local
    task automatic test_idle();
        acc(4'h1, 1'b1, 1'b1, 1'b0, 1'b1, 20'h0abcd);
        acc(4'h2, 1'b0, 1'b0, 1'b0, 1'b0, 20'h00000);
        chk({addrOut, chipSelectN, byteHighEnableN, writeN, readN, dataOe,
            ale}, {20'h0abcd, 6'h0d});
        // second stop cycle lets the retention checks see two samples
        next_edge();
        acc(4'h4, 1'b0, 1'b0, 1'b0, 1'b0, 20'h00000);
        chk({addrOut, chipSelectN, byteHighEnableN, writeN, readN, dataOe,
            ale}, {20'h0abcd, 6'h0d});
        next_edge();
        acc(4'h8, 1'b1, 1'b0, 1'b0, 1'b1, 20'h12345);
        chk({addrOut, chipSelectN, writeN, readN, dataOe},
            {20'h12345, 4'h4});
        acc(4'h8, 1'b1, 1'b1, 1'b0, 1'b1, 20'h12345);
        chk({writeN, dataOe}, 2'h2);
        acc(4'h8, 1'b1, 1'b0, 1'b1, 1'b0, 20'h00500);
        chk({addrOut, chipSelectN, readN}, {20'h00500, 2'h3});
        $display("test idle done");
    endtask : test_idle
    task automatic test_hold();
        acc(4'h1, 1'b0, 1'b0, 1'b0, 1'b0, 20'h00000);
        next_edge();
        holdReqN = 1'b0;
        repeat (3) next_edge();
        chk(holdActive, 1'b0);
        next_edge();
        chk({holdActive, addrOe}, 2'h2);
        acc(4'h1, 1'b1, 1'b0, 1'b0, 1'b1, 20'h12345);
        chk({addrOe, dataOe, readN, writeN}, 4'h3);
        next_edge();
        holdReqN = 1'b1;
        repeat (3) next_edge();
        $display("test hold done");
    endtask : test_hold
    task automatic print_verdict();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict
    initial begin
        #200000;
        failures++;
        print_verdict();
    end
    initial begin
        repeat (8) @(posedge clk);
        #1;
        resetn = 1'b1;
        test_ext();
        test_local();
        test_idle();
        test_hold();
        print_verdict();
    end
endmodule : emulator_external_bus_pin_states_test
`default_nettype wire
